//--- rtl/epsir_regs.sv
// endpoint select, control function and interrupt enable registers
`timescale 1ns/1ps
`include "epsir_defs.svh"
module epsir_regs
    import epsir_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        bus_reset,
    input  wire logic [7:0]  address,
    input  wire logic [31:0] write_data,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    output logic      [31:0] read_data,
    input  wire logic [31:0] event_in,
    input  wire logic        data_stage_done,
    input  wire logic        status_stage_done,
    input  wire logic        setup_token,
    input  wire logic        rx_read_empty,
    input  wire logic        tx_full_packet,
    output logic      [7:0]  endpoint_select,
    output epsir_buf_t       buffer_kind,
    output logic             select_setup_misuse,
    output logic             clear_buffer_pulse,
    output logic             validate_packet_pulse,
    output logic             data_stage_enable,
    output logic             status_ack,
    output logic             stall,
    output logic             data_stage_nak,
    output logic             status_stage_nak,
    output logic             irq
);
    // ==================================================
    // decode
    logic wr_sel;
    logic wr_cf;
    logic wr_mask;
    logic wr_stat;
    assign wr_sel  = write_strobe && address == `EPSIR_OFF_EP_SELECT;
    assign wr_cf   = write_strobe && address == `EPSIR_OFF_CTRL_FUNC;
    assign wr_mask = write_strobe && address == `EPSIR_OFF_IRQ_MASK;
    assign wr_stat = write_strobe && address == `EPSIR_OFF_IRQ_STATUS;

    // ==================================================
    // interrupt enable mask
    logic [31:0] mask_q;
    always_ff @(posedge clock)
    begin
        if (reset)
            mask_q <= `EPSIR_IE_RESET;
        else if (wr_mask)
            mask_q <= write_data & `EPSIR_IE_WRITABLE;
    end

    // ==================================================
    // endpoint select
    logic [5:0] sel_q;
    always_ff @(posedge clock)
    begin
        if (reset)
            sel_q <= 6'(`EPSIR_SEL_RESET);
        else if (wr_sel)
            sel_q <= write_data[5:0];
        else if (bus_reset)
            sel_q <= {sel_q[`EPSIR_SEL_SETUP], 5'h00};
    end
    assign endpoint_select = {2'b00, sel_q};

    // ==================================================
    // control function; clear and validate are command pulses
    localparam logic [4:0] CF_RST = `EPSIR_CF_RESET;
    logic       clear_buffer_q;
    logic       valid_q;
    logic       data_stage_enable_q;
    logic       ack_q;
    logic       stall_q;
    logic [4:0] cf_q;
    assign cf_q = {clear_buffer_q, valid_q, data_stage_enable_q, ack_q, stall_q};

    always_ff @(posedge clock)
    begin
        if (reset || bus_reset)
            clear_buffer_q <= CF_RST[`EPSIR_CF_CLEAR_BUFFER];
        else
            clear_buffer_q <= wr_cf && write_data[`EPSIR_CF_CLEAR_BUFFER];
    end

    always_ff @(posedge clock)
    begin
        if (reset || bus_reset)
            valid_q <= CF_RST[`EPSIR_CF_VALID];
        else
            valid_q <= wr_cf && write_data[`EPSIR_CF_VALID];
    end

    // firmware set wins over a hardware clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (reset || bus_reset)
            data_stage_enable_q <= CF_RST[`EPSIR_CF_DATA_STAGE_ENABLE];
        else if (wr_cf && write_data[`EPSIR_CF_DATA_STAGE_ENABLE])
            data_stage_enable_q <= 1'b1;
        else if (data_stage_done)
            data_stage_enable_q <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset || bus_reset)
            ack_q <= CF_RST[`EPSIR_CF_STATUS];
        else if (wr_cf && write_data[`EPSIR_CF_STATUS])
            ack_q <= 1'b1;
        else if (status_stage_done || setup_token)
            ack_q <= 1'b0;
    end

    // stall only moves on a control function write or a bus reset
    always_ff @(posedge clock)
    begin
        if (reset || bus_reset)
            stall_q <= CF_RST[`EPSIR_CF_STALL];
        else if (wr_cf)
            stall_q <= write_data[`EPSIR_CF_STALL];
    end

    // ==================================================
    // buffer side outputs, registered
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            clear_buffer_pulse    <= 1'b0;
            validate_packet_pulse <= 1'b0;
            data_stage_nak        <= 1'b1;
            status_stage_nak      <= 1'b1;
        end
        else
        begin
            clear_buffer_pulse    <= cf_q[`EPSIR_CF_CLEAR_BUFFER] || rx_read_empty;
            validate_packet_pulse <= cf_q[`EPSIR_CF_VALID] || tx_full_packet;
            data_stage_nak        <= !cf_q[`EPSIR_CF_DATA_STAGE_ENABLE];
            status_stage_nak      <= !cf_q[`EPSIR_CF_STATUS];
        end
    end
    assign data_stage_enable = cf_q[`EPSIR_CF_DATA_STAGE_ENABLE];
    assign status_ack        = cf_q[`EPSIR_CF_STATUS];
    assign stall             = cf_q[`EPSIR_CF_STALL];

    // ==================================================
    // interrupt and decode submodules
    logic [31:0] status_bits;
    epsir_irq_gate #(.WIDTH(32)) u_irq
    (
        .clock      (clock),
        .reset      (reset),
        .event_in   (event_in & `EPSIR_IE_WRITABLE),
        .clear_bits (wr_stat ? write_data : 32'h0000_0000),
        .mask       (mask_q),
        .status_q   (status_bits),
        .irq_q      (irq)
    );

    epsir_buf_decode u_dec
    (
        .clock        (clock),
        .reset        (reset),
        .select       ({2'b00, sel_q}),
        .buf_kind_q   (buffer_kind),
        .select_bad_q (select_setup_misuse)
    );

    // ==================================================
    // read port, data valid one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
            read_data <= 32'h0000_0000;
        else if (read_strobe)
        begin
            case (address)
                `EPSIR_OFF_IRQ_MASK:   read_data <= mask_q;
                `EPSIR_OFF_IRQ_STATUS: read_data <= status_bits;
                `EPSIR_OFF_EP_SELECT:  read_data <= {26'h0, sel_q};
                // data stage enable always reads back zero
                `EPSIR_OFF_CTRL_FUNC:  read_data <= {27'h0, cf_q & 5'h03};
                default:               read_data <= 32'h0000_0000;
            endcase
        end
        else
            read_data <= 32'h0000_0000;
    end

    // ==================================================
    // checks on mask and select
    a_mask_reserved : assert property (@(posedge clock) disable iff (reset)
        (mask_q[31:26] == 6'h00) && !mask_q[9])
        else $error("reserved mask bit set");
    a_mask_write : assert property (@(posedge clock) disable iff (reset)
        wr_mask |=> (mask_q == ($past(write_data) & `EPSIR_IE_WRITABLE)))
        else $error("mask write not stored");
    a_mask_holds : assert property (@(posedge clock) disable iff (reset)
        !wr_mask |=> $stable(mask_q))
        else $error("mask changed without a write");
    a_bus_reset_keeps : assert property (@(posedge clock) disable iff (reset)
        (bus_reset && !wr_sel) |=> (sel_q[4:0] == 5'h00
            && sel_q[5] == $past(sel_q[5])))
        else $error("bus reset select handling wrong");
    a_select_write : assert property (@(posedge clock) disable iff (reset)
        wr_sel |=> (sel_q == $past(write_data[5:0])))
        else $error("select write not stored");
    a_select_reset_val : assert property (@(posedge clock)
        $fell(reset) |-> (sel_q == 6'h20))
        else $error("select reset value wrong");

    // ==================================================
    // checks on the control function bits and the masked interrupt
    a_data_stage_enable_set : assert property (@(posedge clock) disable iff (reset)
        (wr_cf && write_data[`EPSIR_CF_DATA_STAGE_ENABLE] && !bus_reset) |=> data_stage_enable)
        else $error("data stage enable not set");
    a_data_stage_enable_done : assert property (@(posedge clock) disable iff (reset)
        (data_stage_done && !wr_cf) |=> !data_stage_enable)
        else $error("data stage enable not cleared");
    a_data_stage_enable_nak : assert property (@(posedge clock) disable iff (reset)
        !data_stage_enable |=> data_stage_nak)
        else $error("data stage not refused");
    a_status_set : assert property (@(posedge clock) disable iff (reset)
        (wr_cf && write_data[`EPSIR_CF_STATUS] && !bus_reset) |=> status_ack)
        else $error("status bit not set");
    a_status_clears : assert property (@(posedge clock) disable iff (reset)
        (setup_token && !wr_cf) |=> !status_ack)
        else $error("status bit not cleared on setup");
    a_status_done : assert property (@(posedge clock) disable iff (reset)
        (status_stage_done && !wr_cf) |=> !status_ack)
        else $error("status bit not cleared on completion");
    a_status_nak : assert property (@(posedge clock) disable iff (reset)
        !status_ack |=> status_stage_nak)
        else $error("status stage not refused");
    a_stall_write : assert property (@(posedge clock) disable iff (reset)
        (wr_cf && !bus_reset) |=> (stall == $past(write_data[`EPSIR_CF_STALL])))
        else $error("stall write not stored");
    a_stall_holds : assert property (@(posedge clock) disable iff (reset)
        (!wr_cf && !bus_reset) |=> $stable(stall))
        else $error("stall changed without a write");
    a_ctrl_bus_reset : assert property (@(posedge clock) disable iff (reset)
        bus_reset |=> (cf_q == `EPSIR_CF_RESET))
        else $error("control bits not cleared by bus reset");
    a_clear_pulse : assert property (@(posedge clock) disable iff (reset || bus_reset)
        (wr_cf && write_data[4]) |=> ##1 clear_buffer_pulse)
        else $error("clear buffer not issued");
    a_clear_auto : assert property (@(posedge clock) disable iff (reset)
        rx_read_empty |=> clear_buffer_pulse)
        else $error("receive buffer not cleared after full read");
    a_validate_pulse : assert property (@(posedge clock) disable iff (reset || bus_reset)
        (wr_cf && write_data[3]) |=> ##1 validate_packet_pulse)
        else $error("validate not issued");
    a_validate_auto : assert property (@(posedge clock) disable iff (reset)
        tx_full_packet |=> validate_packet_pulse)
        else $error("full packet not validated");
    a_irq_masked : assert property (@(posedge clock) disable iff (reset)
        (mask_q == 32'h0000_0000) |=> !irq)
        else $error("interrupt raised with every source masked");

    // ==================================================
    // checks on the read port
    a_data_stage_enable_reads_zero : assert property (@(posedge clock) disable iff (reset)
        ($past(read_strobe) && $past(address) == `EPSIR_OFF_CTRL_FUNC) |-> !read_data[2])
        else $error("data stage enable read back");
    a_ctrl_read : assert property (@(posedge clock) disable iff (reset)
        ($past(read_strobe) && $past(address) == `EPSIR_OFF_CTRL_FUNC)
            |-> (read_data == {30'h0, $past(cf_q[1:0])}))
        else $error("control function read wrong");
    a_select_read : assert property (@(posedge clock) disable iff (reset)
        ($past(read_strobe) && $past(address) == `EPSIR_OFF_EP_SELECT)
            |-> (read_data == {26'h0, $past(sel_q)}))
        else $error("select read wrong");
    a_mask_read : assert property (@(posedge clock) disable iff (reset)
        ($past(read_strobe) && $past(address) == `EPSIR_OFF_IRQ_MASK)
            |-> (read_data == $past(mask_q)))
        else $error("mask read wrong");
endmodule // epsir_regs

//--- rtl/epsir_defs.svh
// offsets, field positions, reset values and timing counts of the endpoint select block
`ifndef EPSIR_DEFS_SVH
`define EPSIR_DEFS_SVH
// ==================================================
// register offsets (byte addresses)
`define EPSIR_OFF_CTRL_FUNC   8'h28
`define EPSIR_OFF_EP_SELECT   8'h2C
`define EPSIR_OFF_IRQ_MASK    8'h18
`define EPSIR_OFF_IRQ_STATUS  8'h1C
// ==================================================
// interrupt enable mask fields
`define EPSIR_IE_EP_LO        12
`define EPSIR_IE_EP_HI        25
`define EPSIR_IE_CTRL_IN      11
`define EPSIR_IE_CTRL_OUT     10
`define EPSIR_IE_SETUP        8
`define EPSIR_IE_SUPPLY       7
`define EPSIR_IE_DMA          6
`define EPSIR_IE_SPEED        5
`define EPSIR_IE_RESUME       4
`define EPSIR_IE_SUSPEND      3
`define EPSIR_IE_PSOF         2
`define EPSIR_IE_SOF          1
`define EPSIR_IE_BRST         0
`define EPSIR_IE_WRITABLE     32'h03FF_FDFF
`define EPSIR_IE_RESET        32'h0000_0000
// ==================================================
// endpoint select fields
`define EPSIR_SEL_SETUP       5
`define EPSIR_SEL_NUM_HI      4
`define EPSIR_SEL_NUM_LO      1
`define EPSIR_SEL_DIR         0
`define EPSIR_SEL_RESET       8'h20
// ==================================================
// control function fields
`define EPSIR_CF_CLEAR_BUFFER        4
`define EPSIR_CF_VALID        3
`define EPSIR_CF_DATA_STAGE_ENABLE         2
`define EPSIR_CF_STATUS       1
`define EPSIR_CF_STALL        0
`define EPSIR_CF_RESET        5'h00
// ==================================================
// host-side settle times after an endpoint select write
`define EPSIR_RD_SETTLE_NS    190
`define EPSIR_WR_SETTLE_NS    100
`define EPSIR_CLK_NS          10
`endif

//--- rtl/epsir_pkg.sv
// types of the endpoint select and interrupt enable block
package epsir_pkg;
    typedef enum logic [2:0]
    {
        EPSIR_BUF_SETUP,
        EPSIR_BUF_CTRL_OUT,
        EPSIR_BUF_CTRL_IN,
        EPSIR_BUF_DATA_OUT,
        EPSIR_BUF_DATA_IN
    } epsir_buf_t;
endpackage

//--- rtl/epsir_irq_gate.sv
// interrupt event recorder and mask gate
`timescale 1ns/1ps
`include "epsir_defs.svh"
module epsir_irq_gate
    import epsir_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic [WIDTH-1:0] clear_bits,
    input  wire logic [WIDTH-1:0] mask,
    output logic      [WIDTH-1:0] status_q,
    output logic                  irq_q
);
    // ==================================================
    // sticky recording; masked events are still kept
    always_ff @(posedge clock)
    begin
        if (reset)
            status_q <= '0;
        else
            status_q <= (status_q & ~clear_bits) | event_in;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_q & mask);
    end

    a_irq_gated_by_mask : assert property (@(posedge clock) disable iff (reset)
        irq_q |-> |($past(status_q) & $past(mask)))
        else $error("interrupt raised without an enabled event");
    a_event_is_sticky : assert property (@(posedge clock) disable iff (reset)
        (event_in[0] |=> status_q[0]))
        else $error("event bit not recorded");
endmodule // epsir_irq_gate

//--- rtl/epsir_buf_decode.sv
// decode of the endpoint select byte into a buffer kind
`timescale 1ns/1ps
`include "epsir_defs.svh"
module epsir_buf_decode
    import epsir_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [7:0] select,
    output epsir_buf_t      buf_kind_q,
    output logic            select_bad_q
);
    logic       setup_bit;
    logic [3:0] ep_num;
    logic       dir_bit;
    epsir_buf_t buf_kind_d;
    assign setup_bit = select[`EPSIR_SEL_SETUP];
    assign ep_num    = select[`EPSIR_SEL_NUM_HI:`EPSIR_SEL_NUM_LO];
    assign dir_bit   = select[`EPSIR_SEL_DIR];

    // ==================================================
    always_comb
    begin
        if (ep_num != 4'h0)
            buf_kind_d = dir_bit ? EPSIR_BUF_DATA_IN : EPSIR_BUF_DATA_OUT;
        else if (setup_bit)
            buf_kind_d = EPSIR_BUF_SETUP;
        else
            buf_kind_d = dir_bit ? EPSIR_BUF_CTRL_IN : EPSIR_BUF_CTRL_OUT;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            buf_kind_q   <= EPSIR_BUF_SETUP;
            select_bad_q <= 1'b0;
        end
        else
        begin
            buf_kind_q   <= buf_kind_d;
            // setup bit only legal with index 0, OUT
            select_bad_q <= setup_bit && (ep_num != 4'h0 || dir_bit);
        end
    end

    a_setup_decode : assert property (@(posedge clock) disable iff (reset)
        (select[5:0] == 6'h20) |=> (buf_kind_q == EPSIR_BUF_SETUP))
        else $error("setup buffer not decoded");
endmodule // epsir_buf_decode

//--- tb/epsir_host_model.sv
// microcontroller model that masters the register port
`timescale 1ns/1ps
`include "epsir_defs.svh"
module epsir_host_model
(
    input  wire logic        clock,
    output logic      [7:0]  address,
    output logic      [31:0] write_data,
    output logic             write_strobe,
    output logic             read_strobe,
    input  wire logic [31:0] read_data
);
    // ==================================================
    // settle after a select write
    // the longer read gap is used for writes too, one rule for both
    localparam int settle_cycles = (`EPSIR_RD_SETTLE_NS + `EPSIR_CLK_NS - 1) / `EPSIR_CLK_NS;
    logic sel_dirty = 1'b0;

    task automatic settle();
        if (sel_dirty)
        begin
            repeat (settle_cycles) @(posedge clock);
            sel_dirty = 1'b0;
        end
    endtask

    // ==================================================
    // bus cycles; released lines show the inverse, not the last value
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        settle();
        @(posedge clock);
        address      <= a;
        write_data   <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        address      <= ~a;
        write_data   <= ~d;
        sel_dirty = (a == `EPSIR_OFF_EP_SELECT);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        settle();
        @(posedge clock);
        address     <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        address     <= ~a;
        #1;
        d = read_data;
    endtask

    initial
    begin
        address      = 8'h00;
        write_data   = 32'h0000_0000;
        write_strobe = 1'b0;
        read_strobe  = 1'b0;
    end
endmodule // epsir_host_model

//--- tb/epsir_regs_tb_top.sv
// self-checking bench of the endpoint select and interrupt enable registers
`timescale 1ns/1ps
`include "epsir_defs.svh"
module epsir_regs_tb_top
    import epsir_pkg::*;
;
    // ==================================================
    // signals
    logic        clock, reset, write_strobe, read_strobe, irq;
    logic [7:0]  address, endpoint_select;
    logic [31:0] write_data, read_data, event_in, rd, bit_v;
    logic [5:0]  ctl_q;
    epsir_buf_t  buffer_kind;
    logic        misuse, clr_p, val_p, dse, sack, stall, dnak, snak;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          n_clr = 0;
    int          n_val = 0;
    logic [7:0]  sel_tab [5] = '{8'h20, 8'h00, 8'h01, 8'h02, 8'h0F};
    epsir_buf_t  kind_tab [5] = '{EPSIR_BUF_SETUP, EPSIR_BUF_CTRL_OUT, EPSIR_BUF_CTRL_IN,
                                  EPSIR_BUF_DATA_OUT, EPSIR_BUF_DATA_IN};

    epsir_host_model i_epsir_host_model (.clock(clock), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data));

    epsir_regs i_epsir_regs (.clock(clock), .reset(reset), .bus_reset(ctl_q[5]),
        .address(address), .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data), .event_in(event_in),
        .data_stage_done(ctl_q[4]), .status_stage_done(ctl_q[3]), .setup_token(ctl_q[2]),
        .rx_read_empty(ctl_q[1]), .tx_full_packet(ctl_q[0]),
        .endpoint_select(endpoint_select), .buffer_kind(buffer_kind),
        .select_setup_misuse(misuse), .clear_buffer_pulse(clr_p),
        .validate_packet_pulse(val_p), .data_stage_enable(dse), .status_ack(sack),
        .stall(stall), .data_stage_nak(dnak), .status_stage_nak(snak), .irq(irq));

    always #5 clock = ~clock;

    always @(posedge clock)
    begin
        n_clr <= n_clr + int'(clr_p);
        n_val <= n_val + int'(val_p);
    end

    // ==================================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // event bits and control inputs are pulsed for one cycle together
    task automatic pulse(input logic [31:0] e, input logic [5:0] c);
        @(posedge clock);
        event_in <= e;
        ctl_q    <= c;
        @(posedge clock);
        event_in <= 32'h0000_0000;
        ctl_q    <= 6'h00;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        tally_and_finish();
    end

    // ==================================================
    // tests
    initial
    begin
        clock = 1'b0;
        reset = 1'b1;
        event_in = 32'h0000_0000;
        ctl_q = 6'h00;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        idle(1);
        check("kind_rst", 32'(buffer_kind), 32'(EPSIR_BUF_SETUP));
        check("naks_rst", {dnak, snak}, 32'h0000_0003);
        i_epsir_host_model.bus_read(`EPSIR_OFF_EP_SELECT, rd);
        check("select_rst", rd, 32'h0000_0020);
        i_epsir_host_model.bus_read(`EPSIR_OFF_CTRL_FUNC, rd);
        check("ctrl_rst", rd, 32'h0000_0000);
        i_epsir_host_model.bus_write(`EPSIR_OFF_IRQ_MASK, 32'hFFFF_FFFF);
        i_epsir_host_model.bus_read(`EPSIR_OFF_IRQ_MASK, rd);
        check("mask_reserved", rd, 32'h03FF_FDFF);
        pulse(32'h0000_0200, 6'h00);
        idle(3);
        check("irq_reserved", irq, 32'h0000_0000);
        i_epsir_host_model.bus_write(`EPSIR_OFF_IRQ_MASK, 32'h0000_0000);
        for (int i = 0; i < 26; i++)
        begin
            if (i == 9) continue;
            bit_v = 32'h0000_0001 << i;
            pulse(bit_v, 6'h00);
            idle(2);
            check("irq_masked", irq, 32'h0000_0000);
            i_epsir_host_model.bus_read(`EPSIR_OFF_IRQ_STATUS, rd);
            check("event_recorded", rd & bit_v, bit_v);
            i_epsir_host_model.bus_write(`EPSIR_OFF_IRQ_MASK, bit_v);
            idle(2);
            check("irq_enabled", irq, 32'h0000_0001);
            i_epsir_host_model.bus_write(`EPSIR_OFF_IRQ_STATUS, bit_v);
            idle(2);
            check("irq_cleared", irq, 32'h0000_0000);
            i_epsir_host_model.bus_write(`EPSIR_OFF_IRQ_MASK, 32'h0000_0000);
        end
        // the dma endpoint is never programmed here, so select never meets it
        for (int i = 0; i < 5; i++)
        begin
            i_epsir_host_model.bus_write(`EPSIR_OFF_EP_SELECT, {24'h0, sel_tab[i]});
            idle(2);
            check("buffer_kind", 32'(buffer_kind), 32'(kind_tab[i]));
            check("no_misuse", misuse, 32'h0000_0000);
            check("select_port", endpoint_select, {24'h0, sel_tab[i]});
            i_epsir_host_model.bus_read(`EPSIR_OFF_EP_SELECT, rd);
            check("select_rb", rd, {24'h0, sel_tab[i]});
        end
        i_epsir_host_model.bus_write(`EPSIR_OFF_EP_SELECT, 32'h0000_00E2);
        idle(2);
        check("misuse", misuse, 32'h0000_0001);
        i_epsir_host_model.bus_read(`EPSIR_OFF_EP_SELECT, rd);
        check("select_top", rd, 32'h0000_0022);
        // select is written before the first control function write and again after it
        i_epsir_host_model.bus_write(`EPSIR_OFF_EP_SELECT, 32'h0000_000F);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0003);
        i_epsir_host_model.bus_write(`EPSIR_OFF_EP_SELECT, 32'h0000_0020);
        i_epsir_host_model.bus_write(`EPSIR_OFF_IRQ_MASK, 32'h0000_0005);
        pulse(32'h0000_0000, 6'h20);
        i_epsir_host_model.bus_read(`EPSIR_OFF_EP_SELECT, rd);
        check("select_busrst", rd, 32'h0000_0020);
        i_epsir_host_model.bus_read(`EPSIR_OFF_CTRL_FUNC, rd);
        check("ctrl_busrst", rd, 32'h0000_0000);
        i_epsir_host_model.bus_read(`EPSIR_OFF_IRQ_MASK, rd);
        check("mask_busrst", rd, 32'h0000_0005);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0004);
        idle(2);
        check("data_stage_enable_set", {dse, dnak}, 32'h0000_0002);
        i_epsir_host_model.bus_read(`EPSIR_OFF_CTRL_FUNC, rd);
        check("data_stage_enable_read", rd, 32'h0000_0000);
        pulse(32'h0000_0000, 6'h10);
        idle(2);
        check("data_stage_enable_done", {dse, dnak}, 32'h0000_0001);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0002);
        idle(2);
        check("status_set", {sack, snak}, 32'h0000_0002);
        pulse(32'h0000_0000, 6'h04);
        idle(2);
        check("status_setup", {sack, snak}, 32'h0000_0001);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0002);
        pulse(32'h0000_0000, 6'h08);
        idle(2);
        check("status_done", sack, 32'h0000_0000);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0001);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0011);
        idle(4);
        check("clear_once", n_clr, 32'h0000_0001);
        check("stall", stall, 32'h0000_0001);
        i_epsir_host_model.bus_read(`EPSIR_OFF_CTRL_FUNC, rd);
        check("ctrl_rb", rd, 32'h0000_0001);
        pulse(32'h0000_0000, 6'h02);
        idle(3);
        check("clear_auto", n_clr, 32'h0000_0002);
        i_epsir_host_model.bus_write(`EPSIR_OFF_CTRL_FUNC, 32'h0000_0009);
        idle(4);
        check("valid_once", n_val, 32'h0000_0001);
        pulse(32'h0000_0000, 6'h01);
        idle(3);
        check("valid_auto", n_val, 32'h0000_0002);
        i_epsir_host_model.bus_write(8'h40, 32'hFFFF_FFFF);
        i_epsir_host_model.bus_read(8'h40, rd);
        check("unmapped", rd, 32'h0000_0000);
        tally_and_finish();
    end
endmodule // epsir_regs_tb_top
